// ===== logic/write_master.sv
// processor-side bus master for single and line write transfers
`timescale 1ns/1ns
module write_master
	import wbus_pkg::*;
(
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// request stream
	input  wire logic          req_valid,
	output logic               req_ready,
	input  wire wreq_s         req,
	// status
	output logic               busy_q,
	output logic               done_q,
	// bus
	wbus_if.master             bus
);
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA} st_e;

	wreq_s        q_req;
	logic         q_valid;
	logic         q_pop;
	wreq_s        cur_q;
	st_e          st_q;
	logic         line_q;
	logic         burst_q;
	logic [1:0]   beat_q;
	logic         ack;
	logic         last_beat;
	logic         start_new;
	logic         tip_q;
	logic [31:0]  addr_q;
	logic         rw_q;
	logic [1:0]   width_q;
	logic         nc_q;
	logic [1:0]   upa_q;
	logic [1:0]   tt_q;
	logic [2:0]   tm_q;
	logic         ts_q;
	logic [31:0]  dout_q;
	logic         oe_q;

	// only one dirty long word in a push
	function automatic logic one_dirty(input logic [3:0] d);
		return (d == 4'h1) || (d == 4'h2) || (d == 4'h4) || (d == 4'h8);
	endfunction : one_dirty

	function automatic logic is_line(input wreq_s r);
		if ((r.kind == REQ_PUSH) && one_dirty(r.dirty))
			return 1'b0;
		return (r.kind == REQ_SIXTEEN_BYTE_MOVE) || (r.kind == REQ_PUSH);
	endfunction : is_line

	// picks the long word for a beat; push with one dirty word uses that word
	function automatic logic [31:0] word_of(input wreq_s r, input logic [1:0] idx);
		return r.data[32*idx +: 32];
	endfunction : word_of

	function automatic logic [1:0] dirty_idx(input logic [3:0] d);
		return d[1] ? 2'h1 : d[2] ? 2'h2 : d[3] ? 2'h3 : 2'h0;
	endfunction : dirty_idx

	req_fifo #(.WIDTH(WREQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   (req),
		.out_valid (q_valid),
		.out_ready (q_pop),
		.out_data  (q_req)
	);

	// tci_n is deliberately never looked at: writes ignore it
	assign ack       = (st_q == ST_DATA) && !bus.ta_n;
	assign last_beat = !line_q || (beat_q == 2'(LINE_BEATS-1));
	// a new transfer starts from idle or right after the last ack, never mid-line
	assign start_new = q_valid && ((st_q == ST_IDLE) || (ack && last_beat));
	assign q_pop     = start_new;

	// sequencing
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st_q    <= ST_IDLE;
			cur_q   <= '0;
			line_q  <= 1'b0;
			burst_q <= 1'b0;
			beat_q  <= BEAT_RST;
		end else if (start_new) begin
			st_q    <= ST_START;
			cur_q   <= q_req;
			line_q  <= is_line(q_req);
			burst_q <= 1'b1;
			beat_q  <= BEAT_RST;
		end else begin
			unique case (st_q)
				ST_IDLE:  st_q <= ST_IDLE;
				ST_START: st_q <= ST_DATA;
				ST_DATA: begin
					if (ack) begin
						if (last_beat)
							st_q <= ST_IDLE;
						else begin
							beat_q <= beat_q + 2'h1;
							if (beat_q == BEAT_RST && !bus.tbi_n) begin
								burst_q <= 1'b0;
								st_q    <= ST_START;
							end else if (!burst_q)
								st_q <= ST_START;
						end
					end
				end
			endcase
		end
	end

	// address and attributes; fresh address per inhibited follow-up
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_q  <= '0;
			rw_q    <= RW_IDLE_READ;
			width_q <= WID_LONG;
			nc_q    <= 1'b0;
			upa_q   <= ATTR_RST;
			tt_q    <= ATTR_RST;
			tm_q    <= '0;
		end else if (start_new) begin
			rw_q    <= 1'b0;
			upa_q   <= q_req.upa;
			tt_q    <= q_req.tt;
			tm_q    <= q_req.tm;
			nc_q    <= (q_req.kind == REQ_NONCACHE) || (q_req.kind == REQ_ALT_SPACE)
				|| (q_req.kind == REQ_LOCKED);
			if (is_line(q_req))
				width_q <= WID_LINE;
			else if (q_req.kind == REQ_PUSH)
				width_q <= WID_LONG;
			else
				width_q <= q_req.width;
			if ((q_req.kind == REQ_PUSH) && one_dirty(q_req.dirty))
				addr_q <= {q_req.addr[31:4], dirty_idx(q_req.dirty), 2'h0};
			else
				addr_q <= q_req.addr;
		end else if (ack && !last_beat && (!burst_q || (beat_q == BEAT_RST && !bus.tbi_n))) begin
			addr_q[3:2] <= addr_q[3:2] + 2'h1;
			width_q     <= WID_LONG;
		end else if (ack && last_beat && !q_valid) begin
			rw_q <= RW_IDLE_READ;
		end
	end

	// start strobe and active flag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ts_q  <= 1'b0;
			tip_q <= 1'b0;
		end else begin
			ts_q <= start_new || (ack && !last_beat && (!burst_q || (beat_q == BEAT_RST && !bus.tbi_n)));
			if (start_new)
				tip_q <= 1'b1;
			else if (ack && last_beat)
				tip_q <= 1'b0;
		end
	end

	// write data lanes; released the clock after the last ack of each strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dout_q <= '0;
			oe_q   <= 1'b0;
		end else if (st_q == ST_START) begin
			oe_q <= 1'b1;
			if (!line_q && (cur_q.kind == REQ_PUSH))
				dout_q <= word_of(cur_q, dirty_idx(cur_q.dirty));
			else if (line_q)
				dout_q <= word_of(cur_q, 2'(cur_q.addr[3:2] + beat_q));
			else
				dout_q <= cur_q.data[31:0];
		end else if (ack) begin
			if (last_beat || !burst_q || (beat_q == BEAT_RST && !bus.tbi_n))
				oe_q <= 1'b0;
			else
				dout_q <= word_of(cur_q, 2'(cur_q.addr[3:2] + beat_q + 2'h1));
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			busy_q <= (st_q != ST_IDLE) || start_new;
			done_q <= ack && last_beat;
		end
	end

	assign bus.addr      = addr_q;
	assign bus.rw        = rw_q;
	assign bus.width     = width_q;
	assign bus.ncache_n  = !nc_q;
	assign bus.upa       = upa_q;
	assign bus.tt        = tt_q;
	assign bus.tm        = tm_q;
	assign bus.ts_n      = !ts_q;
	assign bus.tip_n     = !tip_q;
	assign bus.data_o    = dout_q;
	assign bus.data_oe_n = !oe_q;
endmodule : write_master

// ===== logic/wbus_pkg.sv
// shared constants and types for the write-transfer bus link
package wbus_pkg;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int FIFO_DEPTH = 4;
	localparam int LINE_BEATS = 4;
	// transfer width encodings (hi, lo)
	localparam logic [1:0] WID_LONG = 2'h0;
	localparam logic [1:0] WID_BYTE = 2'h1;
	localparam logic [1:0] WID_WORD = 2'h2;
	localparam logic [1:0] WID_LINE = 2'h3;
	// reset values
	localparam logic       RW_IDLE_READ   = 1'h1;
	localparam logic [1:0] ATTR_RST       = 2'h0;
	localparam logic [1:0] BEAT_RST       = 2'h0;
	// write request reasons
	typedef enum logic [2:0] {
		REQ_PLAIN,
		REQ_NONCACHE,
		REQ_ALT_SPACE,
		REQ_LOCKED,
		REQ_WRITE_THRU,
		REQ_NO_ALLOC,
		REQ_SIXTEEN_BYTE_MOVE,
		REQ_PUSH
	} req_kind_e;
	typedef struct packed {
		req_kind_e          kind;
		logic [1:0]         width;
		logic [ADDR_W-1:0]  addr;
		logic [1:0]         upa;
		logic [1:0]         tt;
		logic [2:0]         tm;
		logic [3:0]         dirty;
		logic [127:0]       data;
	} wreq_s;
	localparam int WREQ_W = $bits(wreq_s);
endpackage : wbus_pkg

// ===== logic/wbus_if.sv
// bus link between the write master and the selected memory device
`timescale 1ns/1ns
interface wbus_if;
	logic [31:0] addr;
	logic [1:0]  upa;
	logic [1:0]  tt;
	logic [2:0]  tm;
	logic        rw;
	logic [1:0]  width;
	logic        ncache_n;
	logic        ts_n;
	logic        tip_n;
	logic [31:0] data_o;
	logic        data_oe_n;
	logic        ta_n;
	logic        tbi_n;
	logic        tci_n;
	modport master (output addr, upa, tt, tm, rw, width, ncache_n, ts_n, tip_n, data_o, data_oe_n,
		input ta_n, tbi_n, tci_n);
	modport slave (input addr, upa, tt, tm, rw, width, ncache_n, ts_n, tip_n, data_o, data_oe_n,
		output ta_n, tbi_n, tci_n);
endinterface : wbus_if

// ===== logic/req_fifo.sv
// small valid/ready fifo for queued write requests
`timescale 1ns/1ns
module req_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wp_q;
	logic [PW-1:0]    rp_q;
	logic [PW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge mclk) begin
		if (push)
			mem[wp_q] <= in_data;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wp_q <= (wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : req_fifo

// ===== logic/write_target.sv
// selected memory device end: latches write lanes and acknowledges
`timescale 1ns/1ns
module write_target
	import wbus_pkg::*;
(
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// device behaviour
	input  wire logic          refuse_burst,
	input  wire logic [1:0]    wait_states,
	// captured write
	output logic               wr_valid_q,
	output logic [31:0]        wr_addr_q,
	output logic [31:0]        wr_data_q,
	output logic [3:0]         wr_lanes_q,
	output logic               wr_noncache_q,
	// bus
	wbus_if.slave              bus
);
	logic        act_q;
	logic        line_q;
	logic        first_q;
	logic [1:0]  wait_q;
	logic [31:0] a_q;
	logic [1:0]  w_q;
	logic        ta_q;
	logic        tbi_q;
	logic        hit;
	logic [3:0]  lane_sel;

	// lanes from width and low address bits, bits 31..24 are lane 3
	function automatic logic [3:0] lanes(input logic [1:0] w, input logic [1:0] a);
		unique case (w)
			WID_BYTE: lanes = 4'h8 >> a;
			WID_WORD: lanes = a[1] ? 4'h3 : 4'hc;
			default:  lanes = 4'hf;
		endcase
	endfunction : lanes

	// the device latches the lanes in the clock it acknowledges
	assign hit      = act_q && ta_q;
	assign lane_sel = lanes(w_q, a_q[1:0]);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			act_q   <= 1'b0;
			line_q  <= 1'b0;
			first_q <= 1'b0;
			wait_q  <= '0;
			a_q     <= '0;
			w_q     <= WID_LONG;
			ta_q    <= 1'b0;
			tbi_q   <= 1'b0;
		end else begin
			ta_q <= 1'b0;
			if (!bus.ts_n && !bus.rw) begin
				act_q   <= 1'b1;
				line_q  <= (bus.width == WID_LINE);
				first_q <= 1'b1;
				a_q     <= bus.addr;
				w_q     <= bus.width;
				wait_q  <= wait_states;
				// a zero-wait device answers in the clock right after the strobe
				ta_q    <= (wait_states == 2'h0);
				tbi_q   <= (bus.width == WID_LINE) && refuse_burst;
			end else if (act_q && !ta_q) begin
				wait_q <= wait_q - 2'h1;
				if (wait_q <= 2'h1) begin
					ta_q  <= 1'b1;
					tbi_q <= first_q && line_q && refuse_burst;
				end
			end else if (ta_q) begin
				first_q <= 1'b0;
				tbi_q   <= 1'b0;
				if (line_q && !tbi_q && (a_q[3:2] != bus.addr[3:2] - 2'h1)) begin
					a_q[3:2] <= a_q[3:2] + 2'h1;
					wait_q   <= wait_states;
					ta_q     <= (wait_states == 2'h0);
				end else
					act_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_valid_q    <= 1'b0;
			wr_addr_q     <= '0;
			wr_data_q     <= '0;
			wr_lanes_q    <= '0;
			wr_noncache_q <= 1'b0;
		end else begin
			wr_valid_q <= hit;
			if (hit) begin
				wr_addr_q     <= {a_q[31:2], 2'h0};
				wr_lanes_q    <= lanes(w_q, a_q[1:0]);
				wr_noncache_q <= !bus.ncache_n;
				for (int i = 0; i < 4; i++)
					wr_data_q[8*i +: 8] <= lane_sel[i] ? bus.data_o[8*i +: 8] : 8'h0;
			end
		end
	end

	assign bus.ta_n  = !ta_q;
	assign bus.tbi_n = !(ta_q && tbi_q);
	// raised with every ack so that the master's disregard of it is exercised
	assign bus.tci_n = !ta_q;
endmodule : write_target

// ===== tb/wbus_properties.sv
// concurrent checks on the write bus link
`timescale 1ns/1ns
module wbus_properties
	import wbus_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// link
	input wire logic [31:0] addr,
	input wire logic        rw,
	input wire logic [1:0]  width,
	input wire logic        ts_n,
	input wire logic        tip_n,
	input wire logic        data_oe_n,
	input wire logic        ta_n,
	input wire logic        tbi_n
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	chk_strobe_one_clock: assert property (!ts_n |=> ts_n) else $error("strobe too long");
	chk_write_direction: assert property (!ts_n |-> !rw) else $error("start without write");
	chk_active_with_strobe: assert property (!ts_n |-> !tip_n) else $error("start while idle");
	chk_data_driven: assert property (!ts_n |=> !data_oe_n) else $error("data not driven");
	chk_bus_release: assert property ($rose(tip_n) |-> data_oe_n) else $error("data held after end");
	// wait states of a single write count as well: address stands until the next start
	chk_addr_held: assert property ((ts_n && !$past(tip_n)) |-> $stable(addr)) else $error("address moved");
	chk_ack_bounded: assert property (!ts_n |-> ##[1:4] !ta_n) else $error("no ack");
	chk_inhibit_step: assert property ((!ta_n && !tbi_n && width == WID_LINE) |=>
		(!ts_n && width == WID_LONG && addr[3:2] == $past(addr[3:2]) + 2'h1)) else $error("bad follow-up");
	cov_burst: cover property (!ta_n && tbi_n && width == WID_LINE);
	cov_inhibit: cover property (!ta_n && !tbi_n);
	cov_wait: cover property (!ts_n ##1 ta_n ##1 ta_n);
endmodule : wbus_properties

// ===== tb/tb_cpu_bus_write_transfers.sv
// self-checking bench for the write master and target pair
`timescale 1ns/1ns
module tb_cpu_bus_write_transfers;
	import wbus_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        req_valid = 1'b0;
	logic        refuse_burst = 1'b0;
	logic [1:0]  wait_states = 2'h0;
	wreq_s       req = '0;
	logic        req_ready, busy_q, done_q, wr_valid_q, wr_noncache_q;
	logic [31:0] wr_addr_q, wr_data_q;
	logic [3:0]  wr_lanes_q;
	int          err_count = 0, check_count = 0, cyc = 0, tip_cnt = 0, tip_up = 0, done_cnt = 0, sent = 0;
	logic        tip_prev = 1'b1, saw_full = 1'b0;
	logic [31:0] qa[$], qd[$];
	logic [3:0]  ql[$];
	logic [1:0]  qn[$];
	wbus_if wbus_if_inst ();
	write_master write_master_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
		.req(req), .busy_q(busy_q), .done_q(done_q), .bus(wbus_if_inst));
	write_target write_target_inst (.mclk(mclk), .rst(rst), .refuse_burst(refuse_burst),
		.wait_states(wait_states), .wr_valid_q(wr_valid_q), .wr_addr_q(wr_addr_q), .wr_data_q(wr_data_q),
		.wr_lanes_q(wr_lanes_q), .wr_noncache_q(wr_noncache_q), .bus(wbus_if_inst));
	wbus_properties wbus_properties_inst (.mclk(mclk), .rst(rst), .addr(wbus_if_inst.addr),
		.rw(wbus_if_inst.rw), .width(wbus_if_inst.width), .ts_n(wbus_if_inst.ts_n), .tip_n(wbus_if_inst.tip_n),
		.data_oe_n(wbus_if_inst.data_oe_n), .ta_n(wbus_if_inst.ta_n), .tbi_n(wbus_if_inst.tbi_n));
	initial forever #5 mclk = ~mclk;
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end
	// beats are compared in arrival order, so back-to-back traffic needs no extra bookkeeping
	always @(negedge mclk) begin
		if (wr_valid_q === 1'b1) begin
			chk("beat count", qa.size() > 0, 32'h1);
			chk("beat addr", wr_addr_q, qa.pop_front());
			chk("beat data", wr_data_q, qd.pop_front());
			chk("beat lanes", 32'(wr_lanes_q), 32'(ql.pop_front()));
			if (qn[0] != 2'h2) chk("noncache", 32'(wr_noncache_q), 32'(qn[0][0]));
			void'(qn.pop_front());
		end
		if (wbus_if_inst.tip_n === 1'b0) tip_cnt++;
		if (done_q === 1'b1) done_cnt++;
		if (wbus_if_inst.tip_n === 1'b1 && tip_prev === 1'b0) tip_up++;
		tip_prev = wbus_if_inst.tip_n;
		if (req_valid && req_ready === 1'b0) saw_full = 1'b1;
	end
	task automatic send(req_kind_e k, logic [1:0] w, logic [31:0] a, logic [3:0] dt);
		logic [127:0] d;
		logic [3:0]   l;
		logic [1:0]   j;
		d = {~a ^ 32'h3, ~a ^ 32'h2, ~a ^ 32'h1, ~a};
		l = w == WID_BYTE ? 4'h8 >> a[1:0] : w == WID_WORD ? (a[1] ? 4'h3 : 4'hc) : 4'hf;
		sent++;
		if (k == REQ_SIXTEEN_BYTE_MOVE || (k == REQ_PUSH && $countones(dt) > 1)) begin
			for (int i = 0; i < 4; i++) begin
				j = a[3:2] + 2'(i);
				qa.push_back({a[31:4], j, 2'h0});
				qd.push_back(d[j * 32 +: 32]);
				ql.push_back(4'hf);
				qn.push_back(2'h2);
			end
		end else if (k == REQ_PUSH) begin
			j = dt[3] ? 2'h3 : dt[2] ? 2'h2 : dt[1] ? 2'h1 : 2'h0;
			qa.push_back({a[31:4], j, 2'h0});
			qd.push_back(d[j * 32 +: 32]);
			ql.push_back(4'hf);
			qn.push_back(2'h0);
		end else begin
			qa.push_back({a[31:2], 2'h0});
			qd.push_back(~a & {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}});
			ql.push_back(l);
			qn.push_back({1'b0, k inside {REQ_NONCACHE, REQ_ALT_SPACE, REQ_LOCKED}});
		end
		@(negedge mclk);
		req_valid = 1'b1;
		req = '{kind: k, width: w, addr: a, upa: 2'h1, tt: 2'h0, tm: 3'h1, dirty: dt, data: d};
		while (req_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
	endtask : send
	task automatic drain(int et);
		int n;
		n = 0;
		@(negedge mclk);
		req_valid = 1'b0;
		while ((qa.size() != 0 || busy_q !== 1'b0) && n < 300) begin
			@(negedge mclk);
			n++;
		end
		repeat (2) @(posedge mclk);
		chk("beats left", qa.size(), 32'h0);
		chk("active clocks", tip_cnt, et);
		chk("active spans", tip_up, 32'h1);
		chk("done pulses", done_cnt, sent);
		tip_cnt = 0;
		tip_up = 0;
		done_cnt = 0;
		sent = 0;
	endtask : drain
	initial begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		chk("idle strobe", 32'(wbus_if_inst.ts_n), 32'h1);
		chk("idle drive", 32'(wbus_if_inst.data_oe_n), 32'h1);
		for (int k = 0; k < 6; k++) begin
			send(req_kind_e'(k), WID_LONG, 32'h100 + 32'(k) * 32'h10, 4'h0);
			drain(2);
		end
		send(REQ_PLAIN, WID_BYTE, 32'h201, 4'h0);
		drain(2);
		send(REQ_PLAIN, WID_WORD, 32'h302, 4'h0);
		drain(2);
		send(REQ_SIXTEEN_BYTE_MOVE, WID_LINE, 32'h408, 4'h0);
		drain(5);
		send(REQ_PUSH, WID_LINE, 32'h504, 4'hf);
		drain(5);
		@(negedge mclk);
		refuse_burst = 1'b1;
		send(REQ_SIXTEEN_BYTE_MOVE, WID_LINE, 32'h60c, 4'h0);
		drain(8);
		send(REQ_PUSH, WID_LINE, 32'h700, 4'h4);
		drain(2);
		@(negedge mclk);
		refuse_burst = 1'b0;
		wait_states = 2'h2;
		send(REQ_PLAIN, WID_LONG, 32'h800, 4'h0);
		drain(4);
		@(negedge mclk);
		wait_states = 2'h3;
		// slow acks let the queue fill while the master keeps the cycle active
		for (int i = 0; i < 7; i++) send(REQ_NONCACHE, WID_LONG, 32'h900 + 32'(i) * 32'h4, 4'h0);
		drain(35);
		chk("queue refused", 32'(saw_full), 32'h1);
		complete_run();
	end
endmodule : tb_cpu_bus_write_transfers
